// ==== inc/lmn_defs.svh ====
`ifndef LMN_DEFS_SVH
`define LMN_DEFS_SVH

// Opcode patterns, 16-bit instruction words
`define LMN_OP_MOVW_DISP   16'h8500
`define LMN_MSK_MOVW_DISP  16'hFF00
`define LMN_OP_MOVL_DISP   16'h5000
`define LMN_MSK_MOVL_DISP  16'hF000
`define LMN_OP_EA_MOVE     16'hC700
`define LMN_MSK_EA_MOVE    16'hFF00
`define LMN_OP_CA_STORE    16'h00C3
`define LMN_OP_CBIT_MOVE   16'h0029
`define LMN_OP_LONG_MUL    16'h0007
`define LMN_OP_SWORD_MUL   16'h200F
`define LMN_OP_UWORD_MUL   16'h200E
`define LMN_OP_NEGATE      16'h600B
`define LMN_MSK_REG1       16'hF0FF
`define LMN_MSK_REG2       16'hF00F

// Field positions
`define LMN_RN_LSB         8
`define LMN_RM_LSB         4

// Timing and reset values
`define LMN_MUL_STATES     2
`define LMN_PC_STEP        32'h0000_0002
`define LMN_EA_PC_OFFSET   32'h0000_0004
`define LMN_ALIGN_MASK     32'hFFFF_FFFC
`define LMN_RST_WORD       32'h0000_0000

`endif

// ==== inc/lmn_pkg.sv ====
package lmn_pkg;
  typedef enum logic [3:0] {
    LMN_OP_NONE  = 4'h0,
    LMN_OP_LDW   = 4'h1,
    LMN_OP_LDL   = 4'h2,
    LMN_OP_EA    = 4'h3,
    LMN_OP_CAST  = 4'h4,
    LMN_OP_CBIT  = 4'h5,
    LMN_OP_MULL  = 4'h6,
    LMN_OP_MULSW = 4'h7,
    LMN_OP_MULUW = 4'h8,
    LMN_OP_NEG   = 4'h9,
    LMN_OP_ILL   = 4'hA
  } lmn_op_e;

  // Gray along idle -> memory, multiply -> done and done -> idle
  typedef enum logic [1:0] {
    LMN_ST_IDLE = 2'b00,
    LMN_ST_MEM  = 2'b01,
    LMN_ST_MUL  = 2'b11,
    LMN_ST_DONE = 2'b10
  } lmn_state_e;
endpackage : lmn_pkg

// ==== design/lmn_exec.sv ====
// Summary of operation
// [RULE1] Word load at Rm+2d, sign-extended into r0
// [RULE2] Long load at Rm+4d into Rn
// [RULE3] Effective address 4d+PC+4 into r0
// [RULE4] PC low two bits cleared before adding
// [RULE5] Delay-slot effective address raises illegal slot
// [RULE6] Cache-allocating store writes r0 to @Rn
// [RULE7] Miss to write-back allocates block, no fill
// [RULE8] Store reports translation, protection, page, alignment faults
// [RULE9] Condition bit move writes one or zero
// [RULE10] Long multiply low word, high untouched, 2-5 states
// [RULE11] Signed 16x16 product into result low
// [RULE12] Unsigned 16x16 product into result low
// [RULE13] Negate writes zero minus Rm, one state
// [RULE14] Condition bit untouched, PC advances by two
`timescale 1ns/100ps
`include "lmn_defs.svh"
module lmn_exec
  import lmn_pkg::*;
#(
  parameter int MUL_STATES = `LMN_MUL_STATES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        clk_en_i,
  input  wire logic        insn_valid_i,
  input  wire logic [15:0] insn_i,
  input  wire logic [31:0] insn_pc_i,
  input  wire logic        delay_slot_i,
  input  wire logic        cond_bit_i,
  input  wire logic [31:0] src_reg_i,
  input  wire logic [31:0] dst_reg_i,
  input  wire logic [31:0] reg_zero_i,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        mem_wb_area_i,
  input  wire logic        mem_hit_i,
  input  wire logic        tlb_miss_i,
  input  wire logic        tlb_prot_i,
  input  wire logic        init_write_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             reg_we_o,
  output logic [3:0]       reg_idx_o,
  output logic [31:0]      reg_wdata_o,
  output logic             mul_low_we_o,
  output logic [31:0]      mul_low_o,
  output logic             pc_we_o,
  output logic [31:0]      pc_next_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [1:0]       mem_size_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  output logic             cache_alloc_o,
  output logic             exc_o,
  output logic [2:0]       exc_code_o
);

  // Elaboration check: two to five states only; the 3-bit countdown itself would serve up to eight
  if (MUL_STATES < 2 || MUL_STATES > 5) begin : g_bad_mul
    $error("MUL_STATES must be 2 to 5");
  end

  // Exception codes on exc_code_o
  localparam logic [2:0] EXC_ILL_SLOT = 3'h1;
  localparam logic [2:0] EXC_TLB_MISS = 3'h2;
  localparam logic [2:0] EXC_PROT     = 3'h3;
  localparam logic [2:0] EXC_INIT_WR  = 3'h4;
  localparam logic [2:0] EXC_ADDR     = 3'h5;

  // Single decode shared by the issue path
  function automatic lmn_op_e decode(input logic [15:0] w, input logic slot);
    if ((w & `LMN_MSK_MOVW_DISP) == `LMN_OP_MOVW_DISP) decode = LMN_OP_LDW;
    else if ((w & `LMN_MSK_MOVL_DISP) == `LMN_OP_MOVL_DISP) decode = LMN_OP_LDL;
    else if ((w & `LMN_MSK_EA_MOVE) == `LMN_OP_EA_MOVE) decode = slot ? LMN_OP_ILL : LMN_OP_EA; // [RULE5]
    else if ((w & `LMN_MSK_REG1) == `LMN_OP_CA_STORE) decode = LMN_OP_CAST; // [RULE6]
    else if ((w & `LMN_MSK_REG1) == `LMN_OP_CBIT_MOVE) decode = LMN_OP_CBIT;
    else if ((w & `LMN_MSK_REG2) == `LMN_OP_LONG_MUL) decode = LMN_OP_MULL;
    else if ((w & `LMN_MSK_REG2) == `LMN_OP_SWORD_MUL) decode = LMN_OP_MULSW;
    else if ((w & `LMN_MSK_REG2) == `LMN_OP_UWORD_MUL) decode = LMN_OP_MULUW;
    else if ((w & `LMN_MSK_REG2) == `LMN_OP_NEGATE) decode = LMN_OP_NEG;
    else decode = LMN_OP_NONE;
  endfunction : decode

  lmn_state_e  state_r, state_nxt;
  lmn_op_e     op_r, op_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic        busy_nxt, done_nxt, reg_we_nxt, mul_we_nxt, pc_we_nxt;
  logic [3:0]  idx_nxt;
  logic [31:0] wdata_nxt, mul_nxt, pcn_nxt;
  logic        req_nxt, we_nxt, alloc_nxt, exc_nxt;
  logic [1:0]  size_nxt;
  logic [31:0] addr_nxt, mwd_nxt;
  logic [2:0]  code_nxt;
  lmn_op_e     dec_op;
  logic [31:0] disp4, disp8, ea_sum;
  logic [31:0] prod_long;
  logic signed [31:0] prod_sw;

  // Operand arithmetic
  always_comb begin
    dec_op    = decode(insn_i, delay_slot_i);
    disp4     = {28'h0, insn_i[3:0]};
    disp8     = {24'h0, insn_i[7:0]};
    ea_sum    = (insn_pc_i & `LMN_ALIGN_MASK) + (disp8 << 2) + `LMN_EA_PC_OFFSET; // [RULE3] [RULE4]
    prod_long = dst_reg_i * src_reg_i; // Low word only kept [RULE10]
    prod_sw   = $signed(dst_reg_i[15:0]) * $signed(src_reg_i[15:0]); // [RULE11]
  end

  // Next state and output values
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    cnt_nxt   = cnt_r;
    pc_nxt    = pc_r;
    busy_nxt  = busy_o;
    done_nxt  = 1'b0;
    reg_we_nxt = 1'b0;
    mul_we_nxt = 1'b0;
    pc_we_nxt = 1'b0;
    idx_nxt   = reg_idx_o;
    wdata_nxt = reg_wdata_o;
    mul_nxt   = mul_low_o;
    pcn_nxt   = pc_next_o;
    req_nxt   = mem_req_o;
    we_nxt    = mem_we_o;
    size_nxt  = mem_size_o;
    addr_nxt  = mem_addr_o;
    mwd_nxt   = mem_wdata_o;
    alloc_nxt = cache_alloc_o;
    exc_nxt   = 1'b0;
    code_nxt  = exc_code_o;
    case (state_r)
      LMN_ST_IDLE: begin
        if (insn_valid_i && dec_op != LMN_OP_NONE) begin
          op_nxt   = dec_op;
          pc_nxt   = insn_pc_i;
          idx_nxt  = insn_i[11:8];
          pcn_nxt  = insn_pc_i + `LMN_PC_STEP; // Condition bit never written [RULE14]
          case (dec_op)
            LMN_OP_LDW: begin
              idx_nxt = 4'h0;
              state_nxt = LMN_ST_MEM; req_nxt = 1'b1; we_nxt = 1'b0; size_nxt = 2'h1;
              addr_nxt = src_reg_i + (disp4 << 1); // [RULE1]
              busy_nxt = 1'b1;
            end
            LMN_OP_LDL: begin
              state_nxt = LMN_ST_MEM; req_nxt = 1'b1; we_nxt = 1'b0; size_nxt = 2'h2;
              addr_nxt = src_reg_i + (disp4 << 2); // [RULE2]
              busy_nxt = 1'b1;
            end
            LMN_OP_CAST: begin
              // Faults checked before any write goes out [RULE8]
              if (tlb_miss_i || tlb_prot_i || init_write_i || dst_reg_i[1:0] != 2'h0) begin
                exc_nxt  = 1'b1;
                done_nxt = 1'b1;
                code_nxt = tlb_miss_i ? EXC_TLB_MISS : tlb_prot_i ? EXC_PROT :
                           init_write_i ? EXC_INIT_WR : EXC_ADDR;
              end else begin
                state_nxt = LMN_ST_MEM; req_nxt = 1'b1; we_nxt = 1'b1; size_nxt = 2'h2;
                addr_nxt  = dst_reg_i;
                mwd_nxt   = reg_zero_i; // [RULE6]
                alloc_nxt = mem_wb_area_i && !mem_hit_i; // Allocate without fill [RULE7]
                busy_nxt  = 1'b1;
              end
            end
            LMN_OP_ILL: begin
              exc_nxt = 1'b1; done_nxt = 1'b1; code_nxt = EXC_ILL_SLOT; // [RULE5]
            end
            LMN_OP_EA: begin
              idx_nxt = 4'h0; wdata_nxt = ea_sum; reg_we_nxt = 1'b1;
              done_nxt = 1'b1; pc_we_nxt = 1'b1;
            end
            LMN_OP_CBIT: begin
              wdata_nxt = {31'h0, cond_bit_i}; reg_we_nxt = 1'b1; // [RULE9]
              done_nxt = 1'b1; pc_we_nxt = 1'b1;
            end
            LMN_OP_NEG: begin
              wdata_nxt = 32'h0 - src_reg_i; reg_we_nxt = 1'b1; // One state [RULE13]
              done_nxt = 1'b1; pc_we_nxt = 1'b1;
            end
            default: begin
              // Multiplies: result high word has no port here [RULE10]
              state_nxt = LMN_ST_MUL; cnt_nxt = 3'(MUL_STATES - 1); busy_nxt = 1'b1;
              mul_nxt = (dec_op == LMN_OP_MULL) ? prod_long :
                        (dec_op == LMN_OP_MULSW) ? prod_sw :
                        {16'h0, dst_reg_i[15:0]} * {16'h0, src_reg_i[15:0]}; // [RULE12]
            end
          endcase
        end
      end
      LMN_ST_MEM: begin
        if (mem_ack_i) begin
          req_nxt = 1'b0; alloc_nxt = 1'b0; state_nxt = LMN_ST_DONE;
          if (op_r == LMN_OP_LDW) begin
            wdata_nxt = {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]}; reg_we_nxt = 1'b1; // [RULE1]
          end else if (op_r == LMN_OP_LDL) begin
            wdata_nxt = mem_rdata_i; reg_we_nxt = 1'b1; // [RULE2]
          end
        end
      end
      LMN_ST_MUL: begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1) begin
          mul_we_nxt = 1'b1; state_nxt = LMN_ST_DONE; // [RULE10]
        end
      end
      LMN_ST_DONE: begin
        busy_nxt = 1'b0; done_nxt = 1'b1; pc_we_nxt = 1'b1; state_nxt = LMN_ST_IDLE; // [RULE14]
      end
      default: state_nxt = LMN_ST_IDLE;
    endcase
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= LMN_ST_IDLE; op_r <= LMN_OP_NONE; cnt_r <= 3'h0; pc_r <= `LMN_RST_WORD;
      busy_o <= 1'b0; done_o <= 1'b0; reg_we_o <= 1'b0; reg_idx_o <= 4'h0;
      reg_wdata_o <= `LMN_RST_WORD; mul_low_we_o <= 1'b0; mul_low_o <= `LMN_RST_WORD;
      pc_we_o <= 1'b0; pc_next_o <= `LMN_RST_WORD; mem_req_o <= 1'b0; mem_we_o <= 1'b0;
      mem_size_o <= 2'h0; mem_addr_o <= `LMN_RST_WORD; mem_wdata_o <= `LMN_RST_WORD;
      cache_alloc_o <= 1'b0; exc_o <= 1'b0; exc_code_o <= 3'h0;
    end else if (clk_en_i) begin
      state_r <= state_nxt; op_r <= op_nxt; cnt_r <= cnt_nxt; pc_r <= pc_nxt;
      busy_o <= busy_nxt; done_o <= done_nxt; reg_we_o <= reg_we_nxt; reg_idx_o <= idx_nxt;
      reg_wdata_o <= wdata_nxt; mul_low_we_o <= mul_we_nxt; mul_low_o <= mul_nxt;
      pc_we_o <= pc_we_nxt; pc_next_o <= pcn_nxt; mem_req_o <= req_nxt; mem_we_o <= we_nxt;
      mem_size_o <= size_nxt; mem_addr_o <= addr_nxt; mem_wdata_o <= mwd_nxt;
      cache_alloc_o <= alloc_nxt; exc_o <= exc_nxt; exc_code_o <= code_nxt;
    end
  end

endmodule : lmn_exec

// ==== verification/lmn_exec_properties.sv ====
`timescale 1ns/100ps
module lmn_exec_properties
  import lmn_pkg::*;
#(parameter int MUL_STATES = 2) (
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic        clk_en_i,
  input wire logic        insn_valid_i,
  input wire logic [15:0] insn_i,
  input wire logic [31:0] insn_pc_i,
  input wire logic        delay_slot_i,
  input wire logic [31:0] src_reg_i,
  input wire logic        mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        reg_we_o,
  input wire logic [31:0] reg_wdata_o,
  input wire logic        mul_low_we_o,
  input wire logic        pc_we_o,
  input wire logic        mem_req_o,
  input wire logic [1:0]  mem_size_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic        exc_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  // A frozen cycle cancels open attempts instead of failing them
  default disable iff (srst_i || !clk_en_i);
  // Taken requests and the values they should yield; idle takes even in a done cycle
  wire        tk   = insn_valid_i & clk_en_i & ~busy_o;
  wire        ea   = tk & (insn_i[15:8] == 8'hC7);
  wire [31:0] ea_w = (insn_pc_i & 32'hFFFFFFFC) + 32'h4 + {22'h0, insn_i[7:0], 2'b00};
  wire [31:0] ld_w = src_reg_i + {26'h0, insn_i[3:0], 2'b00};
  wire [31:0] sx_w = {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]};
  wire        wack = mem_req_o & mem_ack_i & (mem_size_o == 2'h1);
  a_neg_value: assert property (tk && (insn_i & 16'hF00F) == 16'h600B
    |=> reg_we_o && done_o && pc_we_o && reg_wdata_o == 32'h0 - $past(src_reg_i)) else $error("bad negate");
  a_ea_value: assert property (ea && !delay_slot_i |=> reg_we_o && reg_wdata_o == $past(ea_w))
    else $error("bad address");
  a_ea_slot: assert property (ea && delay_slot_i |=> exc_o && !reg_we_o && !pc_we_o)
    else $error("slot not refused");
  a_mul_time: assert property (tk && (insn_i & 16'hF00F) inside {16'h0007, 16'h200F, 16'h200E}
    |-> ##MUL_STATES mul_low_we_o ##1 (done_o && pc_we_o)) else $error("bad multiply timing");
  a_ldl_addr: assert property (tk && insn_i[15:12] == 4'h5
    |=> mem_req_o && mem_size_o == 2'h2 && mem_addr_o == $past(ld_w)) else $error("bad load address");
  a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o) else $error("request dropped");
  a_ldw_sign: assert property (wack |=> reg_we_o && reg_wdata_o == $past(sx_w)) else $error("bad word load");
  a_load_done: assert property (wack |=> ##1 (done_o && pc_we_o)) else $error("load not finished");
endmodule : lmn_exec_properties

bind lmn_exec lmn_exec_properties #(.MUL_STATES(MUL_STATES)) prop_u (.*);

// ==== verification/lmn_mem_model.sv ====
`timescale 1ns/100ps
module lmn_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wait_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem_r [16];
  logic [3:0]  cnt_r = 4'h0;
  logic        ack_r = 1'b0;
  logic [31:0] rd_r  = 32'h5A5A5A5A;
  assign ack_o   = ack_r;
  assign rdata_o = rd_r;
  // Idle read data toggles, so a stale word never looks valid
  always @(negedge sys_clk_i) begin
    rd_r <= ~rd_r;
    ack_r <= 1'b0;
    cnt_r <= req_i ? cnt_r + 4'h1 : 4'h0;
    if (req_i && !ack_r && cnt_r == wait_i) begin
      ack_r <= 1'b1;
      cnt_r <= 4'h0;
      // Writes leave the read bus toggling, so no unknown sticks to it
      if (we_i) mem_r[addr_i[5:2]] <= wdata_i;
      else rd_r <= mem_r[addr_i[5:2]];
    end
  end
endmodule : lmn_mem_model

// ==== verification/tb_lmn_exec.sv ====
`timescale 1ns/100ps
module tb_lmn_exec;
  import lmn_pkg::*;
  localparam int MS = 3; // Above default, so the wait is really counted
  logic        sys_clk_i, srst_i, insn_valid_i, delay_slot_i, cond_bit_i, mem_ack_i, mem_wb_area_i, mem_hit_i;
  logic        tlb_miss_i, tlb_prot_i, init_write_i, busy_o, done_o, reg_we_o, mul_low_we_o, pc_we_o, exc_o;
  logic        mem_req_o, mem_we_o, cache_alloc_o, al, clk_en_i;
  logic [1:0]  mem_size_o;
  logic [2:0]  exc_code_o, ex;
  logic [3:0]  reg_idx_o, mem_wait, ix;
  logic [15:0] insn_i;
  logic [31:0] insn_pc_i, src_reg_i, dst_reg_i, reg_zero_i, mem_rdata_i, reg_wdata_o, mul_low_o, pc_next_o;
  logic [31:0] mem_addr_o, mem_wdata_o, wd, ml, pn;
  int          dn, bad_count, comparisons;
  lmn_exec #(.MUL_STATES(MS)) dut_u (.*);
  lmn_mem_model mem_u (.sys_clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .wait_i(mem_wait), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("%0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // One-cycle request, then gather answers up to and in the done cycle
  task automatic run(input logic [15:0] op);
    wd = 32'hA5A5A5A5;
    ml = 32'hA5A5A5A5;
    ix = 4'hF;
    al = 1'b0;
    @(negedge sys_clk_i);
    insn_valid_i = 1'b1;
    insn_i = op;
    @(negedge sys_clk_i);
    insn_valid_i = 1'b0;
    // Single-cycle ops write and finish together, so gather before testing done
    for (dn = 0; dn < 40; dn++) begin
      if (reg_we_o === 1'b1) begin
        wd = reg_wdata_o;
        ix = reg_idx_o;
      end
      if (mul_low_we_o === 1'b1) ml = mul_low_o;
      al |= cache_alloc_o === 1'b1;
      if (done_o === 1'b1) break;
      @(negedge sys_clk_i);
    end
    if (dn == 40) bad_count++; // No finish seen counts as a mismatch
    ex = (exc_o === 1'b1) ? exc_code_o : 3'h0;
    pn = (pc_we_o === 1'b1) ? pc_next_o : 32'h0;
    @(negedge sys_clk_i); // Keeps the next request clear of the done cycle
  endtask : run
  task automatic t_single;
    insn_pc_i = 32'h00001006;
    src_reg_i = 32'h00000001;
    run(16'h631B);
    chk(wd, 32'hFFFFFFFF);
    chk(dn, 0);
    chk(pn, 32'h00001008);
    chk(ix, 4'h3);
    src_reg_i = 32'h80000000;
    run(16'h631B);
    chk(wd, 32'h80000000);
    for (int t = 0; t < 2; t++) begin
      cond_bit_i = t[0];
      run(16'h0529);
      chk(wd, {31'h0, t[0]});
      chk(ix, 4'h5);
    end
    run(16'hC7FF);
    chk(wd, 32'h00001404);
    chk(ix, 4'h0);
    delay_slot_i = 1'b1;
    run(16'hC701);
    chk(ex, 3'h1);
    chk(pn, 32'h0);
    delay_slot_i = 1'b0;
  endtask : t_single
  task automatic t_mul;
    logic [15:0] op [3] = '{16'h0107, 16'h210F, 16'h210E};
    logic [31:0] b [3] = '{32'h00005555, 32'h00005555, 32'hFFFFAAAA};
    logic [31:0] p [3] = '{32'hFFFF5556, 32'hFFFF5556, 32'h00015554};
    for (int k = 0; k < 3; k++) begin
      src_reg_i = k == 2 ? 32'h00000002 : 32'hFFFFFFFE;
      dst_reg_i = b[k];
      run(op[k]);
      chk(ml, p[k]);
      chk(dn, MS);
    end
  endtask : t_mul
  // Allocating store on miss and hit, read back slow as long, then as word
  task automatic t_mem;
    mem_wb_area_i = 1'b1;
    dst_reg_i = 32'h00000010;
    reg_zero_i = 32'h12348001;
    run(16'h03C3);
    chk(al, 1'b1);
    mem_hit_i = 1'b1;
    run(16'h03C3);
    chk(al, 1'b0);
    mem_wait = 4'h3;
    src_reg_i = 32'h00000008;
    run(16'h5A02);
    chk(wd, 32'h12348001);
    chk(ix, 4'hA);
    mem_wait = 4'h0;
    src_reg_i = 32'h0000000C;
    run(16'h8502);
    chk(wd, 32'hFFFF8001);
    chk(ix, 4'h0);
  endtask : t_mem
  task automatic t_fault;
    for (int k = 2; k < 6; k++) begin
      tlb_miss_i = k == 2;
      tlb_prot_i = k == 3;
      init_write_i = k == 4;
      dst_reg_i = k == 5 ? 32'h00000011 : 32'h00000010;
      run(16'h03C3);
      chk(ex, k[2:0]);
    end
  endtask : t_fault
  // Negate held off while the clock enable is low, taken once it returns
  task automatic t_freeze;
    src_reg_i = 32'h00000003;
    @(negedge sys_clk_i);
    insn_valid_i = 1'b1;
    insn_i = 16'h631B;
    clk_en_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk(done_o, 1'b0);
    chk(reg_we_o, 1'b0);
    clk_en_i = 1'b1;
    @(negedge sys_clk_i);
    insn_valid_i = 1'b0;
    chk(reg_wdata_o, 32'hFFFFFFFD);
    chk(done_o, 1'b1);
    @(negedge sys_clk_i);
  endtask : t_freeze
  initial begin
    {sys_clk_i, insn_valid_i, delay_slot_i, cond_bit_i, mem_wb_area_i, mem_hit_i, tlb_miss_i} = '0;
    {tlb_prot_i, init_write_i, mem_wait, insn_i, insn_pc_i, src_reg_i, dst_reg_i, reg_zero_i} = '0;
    clk_en_i = 1'b1;
    srst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    srst_i = 1'b0;
    t_single();
    t_mul();
    t_mem();
    t_fault();
    t_freeze();
    stop_test();
  end
  // Run takes some hundred cycles; this only cuts a hang
  initial begin
    #50000;
    bad_count++;
    stop_test();
  end
endmodule : tb_lmn_exec
